/* verilog/dra_pkg.sv */
package dra_pkg;
  // ****************************************
  // timing and units
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;        // 10 MHz system clock
  localparam int TC_UNIT_NS    = 10_000_000; // filter constant step, 0.01 s
  localparam int FILT_FRAC     = 8;          // fraction bits of the filter
  localparam int TORQUE_FULL   = 1000;       // droop gain unit is 0.1 percent
  localparam int PCT_FULL      = 100;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_DROOP_GAIN = 8'h00;
  localparam logic [7:0] OFF_FILT_TC    = 8'h04;
  localparam logic [7:0] OFF_RATED_F    = 8'h08;
  localparam logic [7:0] OFF_MAX_F      = 8'h0c;
  localparam logic [7:0] OFF_RATED_I    = 8'h10;
  localparam logic [7:0] OFF_REGEN_SEL  = 8'h14;
  localparam logic [7:0] OFF_REGEN_LVL  = 8'h18;
  localparam logic [7:0] OFF_REGEN_LIM  = 8'h1c;
  localparam logic [7:0] OFF_REGEN_VG   = 8'h20;
  localparam logic [7:0] OFF_REGEN_FG   = 8'h24;
  localparam logic [7:0] OFF_VIS_SEL    = 8'h28;
  localparam logic [7:0] OFF_STATUS     = 8'h2c;

  // ****************************************
  // reset values and setting ranges
  // ****************************************
  localparam logic [9:0]  DROOP_GAIN_RST = 10'h000;
  localparam logic [9:0]  DROOP_GAIN_MAX = 10'h3e8; // 100.0 percent
  localparam logic [6:0]  TC_RST         = 7'h1e;   // 0.30 s
  localparam logic [6:0]  TC_MAX         = 7'h64;   // 1.00 s
  localparam logic [15:0] RATED_F_RST    = 16'h1770; // 60.00 Hz
  localparam logic [15:0] FREQ_CAP       = 16'h2ee0; // 120.00 Hz
  localparam logic [15:0] RATED_I_RST    = 16'h03e8;
  localparam logic [1:0]  SEL_RST        = 2'h0;
  localparam logic [1:0]  SEL_MAX        = 2'h2;
  localparam logic [9:0]  LVL_LO_RST     = 10'h190; // 400 V class default
  localparam logic [9:0]  LVL_HI_RST     = 10'h30c; // 780 V class default
  localparam logic [9:0]  LVL_MIN        = 10'h12c; // 300 V
  localparam logic [9:0]  LVL_MAX        = 10'h320; // 800 V
  localparam logic [13:0] LIM_RST        = 14'h0258; // 6.00 Hz
  localparam logic [13:0] LIM_MAX        = 14'h03e8; // 10.00 Hz
  localparam logic [13:0] LIM_OFF        = 14'h270f; // limit disabled code
  localparam logic [7:0]  GAIN_RST       = 8'h64;   // 100 percent
  localparam logic [7:0]  GAIN_MAX       = 8'hc8;   // 200 percent
  localparam logic [15:0] VIS_RST        = 16'h0000;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ****************************************
  // types
  // ****************************************
  typedef enum {RG_OFF, RG_ON, RG_HOLD} dra_rg_t;

  typedef struct packed {
    logic signed [15:0] torque;    // torque current, signed counts
    logic [9:0]         bus_volt;  // dc bus voltage, volts
    logic [15:0]        set_freq;  // ramp output frequency, 0.01 Hz
    logic               decel;     // ramp is decelerating
    logic               const_spd; // ramp is at constant speed
  } dra_meas_t;

  typedef struct packed {
    logic ov_stall;      // overvoltage stall indication
    logic overload;      // overload alarm output
    logic stall_prev;    // stall prevention active
    logic ramp_var;      // ramp follows regeneration load
  } dra_flags_t;

  typedef struct packed {
    logic [9:0]  droop_gain;
    logic [6:0]  tc;
    logic [15:0] rated_f;
    logic [15:0] max_f;
    logic [15:0] rated_i;
    logic [1:0]  sel;
    logic [9:0]  level;
    logic [13:0] lim;
    logic [7:0]  vgain;
    logic [7:0]  fgain;
    logic [15:0] vis;
  } dra_cfg_t;

  typedef struct packed {
    dra_cfg_t           cfg;
    dra_rg_t            rg;
    logic               aw_ok;
    logic               w_ok;
    logic [7:0]         awaddr;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic [15:0]        tick;
    logic signed [31:0] filt;
    logic [15:0]        droop;
    logic [15:0]        base;
    logic [15:0]        raise;
    logic [15:0]        base_lat;
    logic [15:0]        hold_f;
    logic [15:0]        out;
    logic               active;
  } dra_st_t;
endpackage

/* verilog/dra_core.sv */
// Operation
// - droop gain zero turns droop off, no torque dependent frequency drop
// - gain 0.1 to 100 percent sets drop at rated torque versus rated frequency
// - torque current is low pass filtered, constant 0 to 1 s, default 0.3 s
// - droop = filtered current / rated current * rated frequency * gain / 100
// - output frequency falls as load torque grows while droop is on
// - droop compensation never exceeds 120 Hz
// - after droop, frequency is clamped to lower of 120 Hz and maximum
// - avoidance select: 0 off, 1 always, 2 only at constant speed
// - enabled and bus voltage at or above level raises the frequency
// - avoidance level 300 to 800 V, default 400 V or 780 V by class
// - compensation limit 0 to 10 Hz, default 6 Hz, caps the raise
// - compensation limit code 9999 removes the cap
// - accelerating or steady, raise capped at start frequency plus limit
// - decelerating past the cap, hold it until frequency falls to half limit
// - raised frequency is clamped to the maximum frequency
// - voltage gain 0 to 200 percent scales avoidance response speed
// - frequency gain 0 to 200 percent scales the applied correction
// - while avoiding, flag overvoltage stall and assert overload alarm
// - while avoiding, stall prevention is also active
// - while avoiding, ramp follows regeneration load, not programmed ramp
// - avoidance settings writable only while visibility select is zero
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
module dra_core
  import dra_pkg::*;
#(
  parameter int         CTRL_CYCLES = 1000,  // clocks per control cycle
  parameter int         REGEN_DIV   = 10000, // volt-gain product per 0.01 Hz step
  parameter int         DECAY_STEP  = 1,     // raise released per control cycle
  parameter logic [9:0] LEVEL_RST   = LVL_LO_RST
) (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RESET,
  // axi4-lite write address and data
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // drive measurements
  input  wire dra_meas_t   MEAS,
  // frequency result and indications
  output logic [15:0]      OUT_FREQ,
  output logic [15:0]      DROOP_FREQ,
  output dra_flags_t       FLAGS
);

  // ****************************************
  // elaboration checks and constants
  // ****************************************
  if (CTRL_CYCLES < 1 || CTRL_CYCLES > 65536 || REGEN_DIV < 1 || DECAY_STEP < 1
      || DECAY_STEP > 65535) begin : g_chk
    $error("dra_core: parameter out of range");
  end

  localparam int TICK_NS = CLK_PERIOD_NS * CTRL_CYCLES;
  localparam logic [15:0] TICK_LAST = 16'(CTRL_CYCLES - 1);
  localparam logic [15:0] DECAY = 16'(DECAY_STEP);

  localparam dra_cfg_t CFG_RST = '{
    droop_gain: DROOP_GAIN_RST, tc: TC_RST, rated_f: RATED_F_RST,
    max_f: FREQ_CAP, rated_i: RATED_I_RST, sel: SEL_RST, level: LEVEL_RST,
    lim: LIM_RST, vgain: GAIN_RST, fgain: GAIN_RST, vis: VIS_RST};

  localparam dra_st_t ST_RST = '{
    cfg: CFG_RST, rg: RG_OFF, aw_ok: 1'b0, w_ok: 1'b0, awaddr: 8'h00,
    wdata: 32'h0000_0000, wstrb: 4'h0, bvalid: 1'b0, bresp: RESP_OKAY,
    rvalid: 1'b0, rdata: 32'h0000_0000, rresp: RESP_OKAY, tick: 16'h0000,
    filt: 32'sh0000_0000, droop: 16'h0000, base: 16'h0000, raise: 16'h0000,
    base_lat: 16'h0000, hold_f: 16'h0000, out: 16'h0000, active: 1'b0};

  dra_st_t st_ff;
  dra_st_t nxt_st;

  // ****************************************
  // helpers
  // ****************************************
  // register read view, used by reads and by byte-lane merges on writes
  function automatic logic [31:0] reg_rd(input logic [7:0] a, input dra_st_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      OFF_DROOP_GAIN: r[9:0]  = s.cfg.droop_gain;
      OFF_FILT_TC:    r[6:0]  = s.cfg.tc;
      OFF_RATED_F:    r[15:0] = s.cfg.rated_f;
      OFF_MAX_F:      r[15:0] = s.cfg.max_f;
      OFF_RATED_I:    r[15:0] = s.cfg.rated_i;
      OFF_REGEN_SEL:  r[1:0]  = s.cfg.sel;
      OFF_REGEN_LVL:  r[9:0]  = s.cfg.level;
      OFF_REGEN_LIM:  r[13:0] = s.cfg.lim;
      OFF_REGEN_VG:   r[7:0]  = s.cfg.vgain;
      OFF_REGEN_FG:   r[7:0]  = s.cfg.fgain;
      OFF_VIS_SEL:    r[15:0] = s.cfg.vis;
      OFF_STATUS:     r = {s.out, 12'h000, s.rg == RG_HOLD, s.rg == RG_ON,
                           s.active, s.droop != 16'h0000};
      default:        r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    return a[1:0] == 2'b00 && a <= OFF_STATUS;
  endfunction

  // byte-lane merge of a write onto the current value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin : next_state
    logic [31:0]        v;
    logic               ok;
    logic               lock;
    logic               tick_now;
    logic               en;
    logic               act;
    logic signed [31:0] xin;
    logic [31:0]        ndiv;
    logic [31:0]        mag;
    logic [47:0]        prod;
    logic [47:0]        den;
    logic [47:0]        q;
    logic signed [17:0] bsum;
    logic [15:0]        fcap;
    logic [9:0]         dv;
    logic [25:0]        step;
    logic [16:0]        rsum;
    logic [16:0]        cap;
    logic [16:0]        pre;
    v        = 32'h0000_0000;
    ok       = 1'b0;
    lock     = 1'b0;
    tick_now = 1'b0;
    en       = 1'b0;
    act      = 1'b0;
    xin      = 32'sh0000_0000;
    ndiv     = 32'h0000_0001;
    mag      = 32'h0000_0000;
    prod     = 48'h0000_0000_0000;
    den      = 48'h0000_0000_0000;
    q        = 48'h0000_0000_0000;
    bsum     = 18'sh0_0000;
    fcap     = 16'h0000;
    dv       = 10'h000;
    step     = 26'h000_0000;
    rsum     = 17'h0_0000;
    cap      = 17'h0_0000;
    pre      = 17'h0_0000;
    nxt_st   = st_ff;

    // write channels taken in either order, response once both are held
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      nxt_st.aw_ok  = 1'b1;
      nxt_st.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      nxt_st.w_ok  = 1'b1;
      nxt_st.wdata = S_AXI_WDATA;
      nxt_st.wstrb = S_AXI_WSTRB;
    end
    if (st_ff.bvalid && S_AXI_BREADY) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.aw_ok && st_ff.w_ok && !st_ff.bvalid) begin
      v    = merge(reg_rd(st_ff.awaddr, st_ff), st_ff.wdata, st_ff.wstrb);
      lock = st_ff.cfg.vis != 16'h0000;
      case (st_ff.awaddr)
        OFF_DROOP_GAIN: begin
          ok = v <= 32'(DROOP_GAIN_MAX);
          if (ok) nxt_st.cfg.droop_gain = v[9:0];
        end
        OFF_FILT_TC: begin
          ok = v <= 32'(TC_MAX);
          if (ok) nxt_st.cfg.tc = v[6:0];
        end
        OFF_RATED_F: begin
          ok = v[31:16] == 16'h0000;
          if (ok) nxt_st.cfg.rated_f = v[15:0];
        end
        OFF_MAX_F: begin
          ok = v[31:16] == 16'h0000;
          if (ok) nxt_st.cfg.max_f = v[15:0];
        end
        OFF_RATED_I: begin
          ok = v[31:16] == 16'h0000;
          if (ok) nxt_st.cfg.rated_i = v[15:0];
        end
        OFF_REGEN_SEL: begin
          ok = !lock && v <= 32'(SEL_MAX);
          if (ok) nxt_st.cfg.sel = v[1:0];
        end
        OFF_REGEN_LVL: begin
          ok = !lock && v >= 32'(LVL_MIN) && v <= 32'(LVL_MAX);
          if (ok) nxt_st.cfg.level = v[9:0];
        end
        OFF_REGEN_LIM: begin
          ok = !lock && (v <= 32'(LIM_MAX) || v == 32'(LIM_OFF));
          if (ok) nxt_st.cfg.lim = v[13:0];
        end
        OFF_REGEN_VG: begin
          ok = !lock && v <= 32'(GAIN_MAX);
          if (ok) nxt_st.cfg.vgain = v[7:0];
        end
        OFF_REGEN_FG: begin
          ok = !lock && v <= 32'(GAIN_MAX);
          if (ok) nxt_st.cfg.fgain = v[7:0];
        end
        OFF_VIS_SEL: begin
          ok = v[31:16] == 16'h0000;
          if (ok) nxt_st.cfg.vis = v[15:0];
        end
        default: ok = 1'b0;
      endcase
      nxt_st.aw_ok  = 1'b0;
      nxt_st.w_ok   = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = ok ? RESP_OKAY : RESP_SLVERR;
    end

    // read answer one cycle after the address is taken
    if (st_ff.rvalid && S_AXI_RREADY) begin
      nxt_st.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = reg_rd(S_AXI_ARADDR, st_ff);
      nxt_st.rresp  = reg_hit(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end

    // control cycle divider
    tick_now    = st_ff.tick == TICK_LAST;
    nxt_st.tick = tick_now ? 16'h0000 : st_ff.tick + 16'h0001;

    // first order lag of the torque current
    xin  = 32'(MEAS.torque) <<< FILT_FRAC;
    ndiv = (32'(st_ff.cfg.tc) * 32'(TC_UNIT_NS)) / 32'(TICK_NS);
    if (ndiv == 32'h0000_0000) ndiv = 32'h0000_0001;
    if (tick_now) begin
      if (st_ff.cfg.tc == 7'h00) begin
        nxt_st.filt = xin;
      end else begin
        nxt_st.filt = st_ff.filt + (xin - st_ff.filt) / $signed(ndiv);
      end
    end

    // droop compensation from the filtered current
    mag  = st_ff.filt[31] ? 32'(-st_ff.filt) : 32'(st_ff.filt);
    prod = 48'(mag >> FILT_FRAC) * 48'(st_ff.cfg.rated_f) * 48'(st_ff.cfg.droop_gain);
    den  = 48'(st_ff.cfg.rated_i) * 48'(TORQUE_FULL);
    if (st_ff.cfg.droop_gain == 10'h000 || den == 48'h0000_0000_0000) begin
      q = 48'h0000_0000_0000;
    end else begin
      q = prod / den;
    end
    nxt_st.droop = q > 48'(FREQ_CAP) ? FREQ_CAP : q[15:0];

    // motoring lowers, regenerating torque raises, then clamp
    fcap = st_ff.cfg.max_f < FREQ_CAP ? st_ff.cfg.max_f : FREQ_CAP;
    if (st_ff.filt[31]) begin
      bsum = 18'(MEAS.set_freq) + 18'(st_ff.droop);
    end else begin
      bsum = 18'(MEAS.set_freq) - 18'(st_ff.droop);
    end
    if (bsum < 18'sh0_0000) begin
      nxt_st.base = 16'h0000;
    end else if (bsum > 18'(fcap)) begin
      nxt_st.base = fcap;
    end else begin
      nxt_st.base = bsum[15:0];
    end

    // regeneration avoidance
    en   = st_ff.cfg.sel == 2'h1 || (st_ff.cfg.sel == 2'h2 && MEAS.const_spd);
    act  = en && MEAS.bus_volt >= st_ff.cfg.level;
    dv   = MEAS.bus_volt - st_ff.cfg.level;
    step = 26'((32'(dv) * 32'(st_ff.cfg.vgain) * 32'(st_ff.cfg.fgain)) / REGEN_DIV);
    cap  = 17'(st_ff.base_lat) + 17'(st_ff.cfg.lim);
    if (tick_now) begin
      case (st_ff.rg)
        RG_OFF: begin
          nxt_st.raise = 16'h0000;
          if (act) begin
            nxt_st.rg       = RG_ON;
            nxt_st.base_lat = st_ff.base; // frequency before avoidance
          end
        end
        RG_ON: begin
          if (act) begin
            rsum = 17'(st_ff.raise) + 17'(step);
          end else begin
            rsum = st_ff.raise > DECAY ? 17'(st_ff.raise - DECAY) : 17'h0_0000;
          end
          if (rsum > 17'h0_ffff) rsum = 17'h0_ffff;
          if (st_ff.cfg.lim != LIM_OFF && 17'(st_ff.base) + rsum > cap) begin
            if (MEAS.decel) begin
              nxt_st.rg     = RG_HOLD;
              nxt_st.hold_f = cap[16] ? 16'hffff : cap[15:0];
            end else begin
              rsum = cap > 17'(st_ff.base) ? cap - 17'(st_ff.base) : 17'h0_0000;
            end
          end
          nxt_st.raise = rsum[15:0];
          if (!act && rsum == 17'h0_0000) nxt_st.rg = RG_OFF;
        end
        RG_HOLD: begin
          if (17'(st_ff.base) <= 17'(st_ff.cfg.lim >> 1)) begin
            nxt_st.rg    = RG_OFF;
            nxt_st.raise = 16'h0000;
          end
        end
        default: nxt_st.rg = RG_OFF;
      endcase
    end
    if (st_ff.cfg.sel == 2'h0) begin
      nxt_st.rg    = RG_OFF;
      nxt_st.raise = 16'h0000;
    end
    nxt_st.active = act || nxt_st.rg == RG_HOLD;

    // final frequency, raised value clamped to the maximum
    pre = st_ff.rg == RG_HOLD ? 17'(st_ff.hold_f) : 17'(st_ff.base) + 17'(st_ff.raise);
    nxt_st.out = pre > 17'(st_ff.cfg.max_f) ? st_ff.cfg.max_f : pre[15:0];
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign S_AXI_AWREADY    = !st_ff.aw_ok && !st_ff.bvalid;
  assign S_AXI_WREADY     = !st_ff.w_ok && !st_ff.bvalid;
  assign S_AXI_BVALID     = st_ff.bvalid;
  assign S_AXI_BRESP      = st_ff.bresp;
  assign S_AXI_ARREADY    = !st_ff.rvalid;
  assign S_AXI_RVALID     = st_ff.rvalid;
  assign S_AXI_RDATA      = st_ff.rdata;
  assign S_AXI_RRESP      = st_ff.rresp;
  assign OUT_FREQ         = st_ff.out;
  assign DROOP_FREQ       = st_ff.droop;
  // avoidance raises all four indications together
  assign FLAGS.ov_stall   = st_ff.active;
  assign FLAGS.overload   = st_ff.active;
  assign FLAGS.stall_prev = st_ff.active;
  assign FLAGS.ramp_var   = st_ff.active;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  sequence wr_lvl_s;
    st_ff.aw_ok && st_ff.w_ok && !st_ff.bvalid && st_ff.awaddr == OFF_REGEN_LVL;
  endsequence

  droop_off_a: assert property (st_ff.cfg.droop_gain == 10'h000 |=> DROOP_FREQ == 16'h0000)
    else $error("droop not zero with zero gain");
  droop_cap_a: assert property (DROOP_FREQ <= FREQ_CAP)
    else $error("droop above 120 Hz");
  base_clamp_a: assert property (st_ff.base <= FREQ_CAP && st_ff.base <= st_ff.cfg.max_f
                                 || $changed(st_ff.cfg.max_f))
    else $error("frequency after droop above clamp");
  out_max_a: assert property (!$changed(st_ff.cfg.max_f) |-> ##1
                              OUT_FREQ <= $past(st_ff.cfg.max_f))
    else $error("output above maximum frequency");
  regen_off_a: assert property (st_ff.cfg.sel == 2'h0 |=> !FLAGS.ov_stall && st_ff.raise == 16'h0000)
    else $error("avoidance active while disabled");
  regen_on_a: assert property (st_ff.cfg.sel == 2'h1 && MEAS.bus_volt >= st_ff.cfg.level
                               |=> FLAGS.ov_stall && FLAGS.overload)
    else $error("avoidance not active above level");
  alarm_pair_a: assert property (FLAGS.ov_stall == FLAGS.overload
                                 && FLAGS.stall_prev == FLAGS.ov_stall)
    else $error("stall and overload indications disagree");
  raise_cap_a: assert property (st_ff.rg == RG_ON && st_ff.cfg.lim != LIM_OFF && !MEAS.decel
                                && st_ff.tick == TICK_LAST && $stable(st_ff.cfg.lim)
                                |=> st_ff.raise == 16'h0000
                                    || 17'(st_ff.base) + 17'(st_ff.raise) <=
                                    17'($past(st_ff.base_lat)) + 17'($past(st_ff.cfg.lim))
                                    || $changed(st_ff.base))
    else $error("raise above start plus limit");
  lock_a: assert property (wr_lvl_s ##0 st_ff.cfg.vis != 16'h0000 |=> $stable(st_ff.cfg.level)
                           ##0 S_AXI_BRESP == RESP_SLVERR)
    else $error("locked level written");
  filt_pass_a: assert property (st_ff.cfg.tc == 7'h00 && st_ff.tick == TICK_LAST
                                |=> st_ff.filt == (32'($past(MEAS.torque)) <<< FILT_FRAC))
    else $error("zero constant did not pass through");

endmodule // dra_core

/* testbench/dra_stage.sv */
`timescale 1ns/1ns
module dra_stage
  import dra_pkg::*;
(
  // plant quantities
  input  wire logic signed [15:0] torque,
  input  wire logic [9:0]         volt,
  input  wire logic [15:0]        freq,
  input  wire logic               decel,
  // sensed values
  output dra_meas_t               meas
);
  // sensing path, steady when not decelerating
  assign meas = '{torque, volt, freq, decel, !decel};
endmodule // dra_stage

/* testbench/dra_core_tb.sv */
`timescale 1ns/1ns
module dra_core_tb
  import dra_pkg::*;
;
  logic clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic awr, wrd, bv, arr, rv;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdata, rd;
  logic [1:0] bresp, rresp;
  logic [15:0] out_f, droop_f, freq = 0;
  logic signed [15:0] torque = 0;
  logic [9:0] volt = 0;
  logic decel = 0;
  dra_flags_t flags;
  dra_meas_t meas;
  int errors = 0, check_count = 0;
  // 100 ns clock
  always #50 clk = ~clk;
  dra_stage stage (.torque(torque), .volt(volt), .freq(freq), .decel(decel), .meas(meas));
  dra_core #(.CTRL_CYCLES(4)) DUT (.CLK_SYS(clk), .RESET(rst), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
    .MEAS(meas), .OUT_FREQ(out_f), .DROOP_FREQ(droop_f), .FLAGS(flags));
  // compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // axi4-lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    br <= 1'b0;
    chk("bresp", 32'(r), 32'(bresp));
  endtask
  // axi4-lite read
  task automatic rdr(input logic [7:0] a, input logic [1:0] r);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rr <= 1'b0;
    rd = rdata;
    chk("rresp", 32'(r), 32'(rresp));
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    rdr(a, RESP_OKAY);
    chk(n, e, rd);
  endtask
  // verdict
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done();
  end
  // test sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rchk("droop_gain", OFF_DROOP_GAIN, 32'h0000_0000);
    rchk("tc", OFF_FILT_TC, 32'h0000_001e);
    rchk("level", OFF_REGEN_LVL, 32'h0000_0190);
    rchk("lim", OFF_REGEN_LIM, 32'h0000_0258);
    rdr(8'h30, RESP_SLVERR);
    wr(OFF_STATUS, 32'h0000_0000, RESP_SLVERR);
    $display("register test done");
    wr(OFF_FILT_TC, 32'h0000_0000, RESP_OKAY);
    freq <= 16'h1388;
    torque <= 16'sh01f4;
    repeat (20) @(posedge clk);
    chk("out gain 0", 32'h0000_1388, 32'(out_f));
    wr(OFF_DROOP_GAIN, 32'h0000_03e8, RESP_OKAY);
    repeat (20) @(posedge clk);
    chk("droop", 32'h0000_0bb8, 32'(droop_f));
    chk("out droop", 32'h0000_07d0, 32'(out_f));
    wr(OFF_MAX_F, 32'h0000_1770, RESP_OKAY);
    torque <= -16'sh7fff;
    repeat (20) @(posedge clk);
    chk("droop cap", 32'h0000_2ee0, 32'(droop_f));
    chk("out clamp", 32'h0000_1770, 32'(out_f));
    $display("droop test done");
    wr(OFF_DROOP_GAIN, 32'h0000_0000, RESP_OKAY);
    torque <= 16'sh0000;
    wr(OFF_REGEN_LIM, 32'h0000_0064, RESP_OKAY);
    volt <= 10'h1f4;
    for (int i = 0; i < 3; i++) begin
      wr(OFF_REGEN_SEL, 32'(i), RESP_OKAY);
      repeat (40) @(posedge clk);
      chk("flags", (i == 0) ? 32'h0 : 32'hf, 32'(flags));
    end
    chk("out cap", 32'h0000_13ec, 32'(out_f));
    wr(OFF_REGEN_SEL, 32'h0000_0001, RESP_OKAY);
    decel <= 1'b1;
    repeat (8) @(posedge clk);
    rchk("status hold", OFF_STATUS, 32'h13ec_000a);
    freq <= 16'h0032;
    decel <= 1'b0;
    repeat (40) @(posedge clk);
    chk("out release", 32'h0000_0096, 32'(out_f));
    freq <= 16'h1388;
    wr(OFF_REGEN_SEL, 32'h0000_0002, RESP_OKAY);
    wr(OFF_REGEN_LIM, 32'h0000_270f, RESP_OKAY);
    repeat (80) @(posedge clk);
    chk("out max", 32'h0000_1770, 32'(out_f));
    decel <= 1'b1;
    repeat (4) @(posedge clk);
    chk("flags decel", 32'h0, 32'(flags));
    wr(OFF_VIS_SEL, 32'h0000_0001, RESP_OKAY);
    wr(OFF_REGEN_SEL, 32'h0000_0000, RESP_SLVERR);
    wr(OFF_REGEN_LVL, 32'h0000_01f4, RESP_SLVERR);
    rchk("level lock", OFF_REGEN_LVL, 32'h0000_0190);
    rchk("sel", OFF_REGEN_SEL, 32'h0000_0002);
    $display("regen test done");
    test_done();
  end
endmodule // dra_core_tb
